// *** hw/dms_pkg.sv ***
// Shared constants, types and parity helpers for the duplicated store
// Contract
// - Go command starts store timing
// - Order done in one cycle, two after refresh
// - Answer before 96 us time-out
// - Completion signalled explicitly, not assumed
// - Parity error rereads mate store
// - Complement write inverts whole word
// - Two parity errors invert read word
// - 4K blocks refuse writes when protected
// - Protection holds until register rewritten
// - Periodic refresh keeps cells alive
// - Reads leave contents unchanged
// - Any address in any cycle
// - 26-bit words, 32K modules, eight max
// - Two bits per plane, thirteen planes
// - Writes go to both stores
// - Bus repeated on to next store
// - Timing from 14.92537 MHz master clock (here it steps refresh only; order cycle and time-out count pclk)
// - Nine-stage refresh counter, duplicated check
package dms_pkg;
    localparam int WORD_W = 26;
    localparam int DATA_W = 24;
    localparam int LO_W = 16;
    localparam int PAR_LO = 24;
    localparam int PAR_HI = 25;
    localparam int ADDR_W = 18;
    localparam int MOD_WORDS = 32768;
    localparam int MAX_MODS = 8;
    localparam int PLANES = 13;
    localparam int PLANE_W = 2;
    localparam int BLK_W = 12;
    localparam int WP_BITS = 64;
    localparam int SEG_W = 8;
    localparam int SEG_SEL_W = 3;
    localparam int REF_ROW_W = 6;
    localparam int REF_STAGES = 9;
    localparam int MEM_CYCLE_CYC = 8;
    localparam int ACC_W = 27;
    localparam int MCLK_HZ = 14925370;
    localparam int PCLK_HZ = 100000000;
    localparam int PCLK_MHZ = 100;
    localparam int TIMEOUT_US = 96;
    localparam int TIMEOUT_CYC = TIMEOUT_US * PCLK_MHZ;
    localparam logic [WP_BITS-1:0] WP_RST = 64'h0;
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] OFS_CTRL = 12'h000;
    localparam logic [APB_AW-1:0] OFS_ADDR = 12'h004;
    localparam logic [APB_AW-1:0] OFS_WDATA = 12'h008;
    localparam logic [APB_AW-1:0] OFS_RDATA = 12'h00c;
    localparam logic [APB_AW-1:0] OFS_STATUS = 12'h010;
    localparam int CTL_START = 0;
    localparam int CTL_CMD = 1;
    localparam int CTL_AUTO = 3;
    localparam int CTL_COMPL = 4;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_TMO = 2;
    localparam int ST_WPE = 3;
    localparam int ST_PERR = 4;
    localparam int ST_MATE = 5;

    typedef enum logic [1:0] {
        CMD_READ = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_WP_LOAD = 2'h2
    } dms_cmd_t;

    // Odd parity: low bit over data 15..0, high bit over data 23..16
    function automatic logic parity_lo_bad(input logic [WORD_W-1:0] w);
        return ~^{w[PAR_LO], w[LO_W-1:0]};
    endfunction

    function automatic logic parity_hi_bad(input logic [WORD_W-1:0] w);
        return ~^{w[PAR_HI], w[DATA_W-1:LO_W]};
    endfunction

    function automatic logic [WORD_W-1:0] add_parity(input logic [DATA_W-1:0] d);
        return {~^d[DATA_W-1:LO_W], ~^d[LO_W-1:0], d};
    endfunction
endpackage

// *** hw/dms_bus_if.sv ***
// Main store bus between processor and one store
interface dms_bus_if;
    import dms_pkg::*;
    logic go;
    dms_cmd_t cmd;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic auto_correct;
    logic compl_write;
    logic busy;
    logic complete;
    logic [WORD_W-1:0] rdata;
    logic wp_error;

    modport proc (
        output go, cmd, addr, wdata, auto_correct, compl_write,
        input busy, complete, rdata, wp_error
    );
    modport store (
        input go, cmd, addr, wdata, auto_correct, compl_write,
        output busy, complete, rdata, wp_error
    );
endinterface

// *** hw/dms_refresh_counter.sv ***
// Refresh request counter stepped by master clock ticks
module dms_refresh_counter #(
    parameter int STAGES = dms_pkg::REF_STAGES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic tick,
    output logic [STAGES-1:0] count,
    output logic wrap
);
    import dms_pkg::*;

    // Free-running count of master ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= '0;
        end else if (ce && tick) begin
            count <= count + 1'b1;
        end
    end

    // Request on every full turn
    assign wrap = ce && tick && (count == '1);
endmodule

// *** hw/dms_store.sv ***
// Store end: order timing, refresh, write protect, bit-sliced cells, repeater
module dms_store #(
    parameter int NUM_MODS = dms_pkg::MAX_MODS,
    parameter int MEM_CYC = dms_pkg::MEM_CYCLE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    dms_bus_if.store bus,
    output logic rep_go,
    output dms_pkg::dms_cmd_t rep_cmd,
    output logic [dms_pkg::ADDR_W-1:0] rep_addr,
    output logic [dms_pkg::WORD_W-1:0] rep_wdata,
    output logic rep_auto_correct,
    output logic rep_compl_write,
    output logic refresh_active,
    output logic counter_mismatch
);
    import dms_pkg::*;

    localparam int DEPTH = NUM_MODS * MOD_WORDS;
    localparam int CYC_W = $clog2(MEM_CYC + 1);
    localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(MEM_CYC - 1);
    localparam logic [ADDR_W:0] DEPTH_V = (ADDR_W + 1)'(DEPTH);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_REFRESH = 3'b010,
        ST_ACCESS = 3'b100
    } dms_store_state_t;

    dms_store_state_t state;
    dms_store_state_t next_state;
    logic [CYC_W-1:0] cyc_cnt;
    logic busy;
    logic ref_pend;
    logic complete;
    logic wp_error;
    logic mismatch;
    dms_cmd_t o_cmd;
    logic [ADDR_W-1:0] o_addr;
    logic [WORD_W-1:0] o_wdata;
    logic o_auto;
    logic o_compl;
    logic [WORD_W-1:0] rdata;
    logic [WORD_W-1:0] rd_word;
    logic [REF_ROW_W-1:0] ref_addr;
    logic [ACC_W-1:0] acc;
    logic [WP_BITS-1:0] wp_reg;
    logic [REF_STAGES-1:0] cnt_a;
    logic [REF_STAGES-1:0] cnt_b;
    logic wrap_a;
    logic wrap_b;

    // Master clock tick from a phase accumulator on pclk
    wire [ACC_W-1:0] acc_sum = acc + ACC_W'(MCLK_HZ);
    wire mtick = acc_sum >= ACC_W'(PCLK_HZ);
    wire [ACC_W-1:0] next_acc = mtick ? acc_sum - ACC_W'(PCLK_HZ) : acc_sum;

    // Order acceptance and cycle decode
    wire take = bus.go && !busy;
    wire cyc_end = cyc_cnt == CYC_LAST;
    wire acc_end = (state == ST_ACCESS) && cyc_end;
    wire ref_end = (state == ST_REFRESH) && cyc_end;
    wire ref_start = (state == ST_IDLE) && (next_state == ST_REFRESH);

    // Address check, protection and data paths
    wire addr_ok = {1'b0, o_addr} < DEPTH_V;
    wire [ADDR_W-BLK_W-1:0] blk = o_addr[ADDR_W-1:BLK_W];
    wire blk_prot = wp_reg[blk];
    wire is_wr = acc_end && (o_cmd == CMD_WRITE);
    wire wr_refused = is_wr && blk_prot;
    wire mem_we = ce && is_wr && !blk_prot && addr_ok;
    wire wp_ld = acc_end && (o_cmd == CMD_WP_LOAD);
    wire [SEG_SEL_W-1:0] seg = o_addr[SEG_SEL_W-1:0];
    wire [WORD_W-1:0] wr_word = o_compl ? ~o_wdata : o_wdata;
    wire [WORD_W-1:0] rd_safe = addr_ok ? rd_word : '0;
    wire both_bad = parity_lo_bad(rd_safe) && parity_hi_bad(rd_safe);
    wire [WORD_W-1:0] rd_out = (o_auto && both_bad) ? ~rd_safe : rd_safe;

    // Duplicated refresh request counters
    dms_refresh_counter #(.STAGES(REF_STAGES)) u_ref_a (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(mtick),
        .count(cnt_a),
        .wrap(wrap_a)
    );

    dms_refresh_counter #(.STAGES(REF_STAGES)) u_ref_b (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .tick(mtick),
        .count(cnt_b),
        .wrap(wrap_b)
    );

    // Sequencer: orders win when idle, refresh in progress runs out first
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (take || busy) begin
                    next_state = ST_ACCESS;
                end else if (ref_pend) begin
                    next_state = ST_REFRESH;
                end
            end
            ST_REFRESH: begin
                if (cyc_end) begin
                    next_state = (take || busy) ? ST_ACCESS : ST_IDLE;
                end
            end
            ST_ACCESS: begin
                if (cyc_end) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // State and memory cycle counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            cyc_cnt <= '0;
            acc <= '0;
        end else if (ce) begin
            state <= next_state;
            cyc_cnt <= (next_state != state) ? '0 : cyc_cnt + 1'b1;
            acc <= next_acc;
        end
    end

    // Busy from acceptance to completion; refresh request, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy <= 1'b0;
            ref_pend <= 1'b0;
            ref_addr <= '0;
            mismatch <= 1'b0;
        end else if (ce) begin
            busy <= take || (busy && !acc_end);
            ref_pend <= wrap_a || (ref_pend && !ref_start);
            if (ref_end) begin
                ref_addr <= ref_addr + 1'b1;
            end
            mismatch <= mismatch || (cnt_a != cnt_b) || (wrap_a != wrap_b);
        end
    end

    // Order capture, any address accepted in any order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            o_cmd <= CMD_READ;
            o_addr <= '0;
            o_wdata <= '0;
            o_auto <= 1'b0;
            o_compl <= 1'b0;
        end else if (ce && take) begin
            o_cmd <= bus.cmd;
            o_addr <= bus.addr;
            o_wdata <= bus.wdata;
            o_auto <= bus.auto_correct;
            o_compl <= bus.compl_write;
        end
    end

    // Write-protect segments, changed only by a load order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_reg <= WP_RST;
        end else if (ce && wp_ld) begin
            wp_reg[seg*SEG_W +: SEG_W] <= o_wdata[SEG_W-1:0];
        end
    end

    // Answer registers: complete pulses one cycle, wp_error held until the next completion, rdata until the next read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            complete <= 1'b0;
            wp_error <= 1'b0;
            rdata <= '0;
        end else if (ce) begin
            complete <= acc_end;
            if (acc_end) begin
                wp_error <= wr_refused;
            end
            if (acc_end && (o_cmd == CMD_READ)) begin
                rdata <= rd_out;
            end
        end
    end

    // Bit-sliced planes, two bits of each word per plane
    for (genvar p = 0; p < PLANES; p++) begin : g_plane
        logic [PLANE_W-1:0] cells [DEPTH];
        always_ff @(posedge pclk) begin
            if (mem_we) begin
                cells[o_addr] <= wr_word[p*PLANE_W +: PLANE_W];
            end
        end
        assign rd_word[p*PLANE_W +: PLANE_W] = cells[o_addr];
    end

    // Repeater to the next store in the chain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rep_go <= 1'b0;
            rep_cmd <= CMD_READ;
            rep_addr <= '0;
            rep_wdata <= '0;
            rep_auto_correct <= 1'b0;
            rep_compl_write <= 1'b0;
        end else if (ce) begin
            rep_go <= bus.go;
            rep_cmd <= bus.cmd;
            rep_addr <= bus.addr;
            rep_wdata <= bus.wdata;
            rep_auto_correct <= bus.auto_correct;
            rep_compl_write <= bus.compl_write;
        end
    end

    // Bus answers and status outputs
    assign bus.busy = busy;
    assign bus.complete = complete;
    assign bus.rdata = rdata;
    assign bus.wp_error = wp_error;
    assign refresh_active = state == ST_REFRESH;
    assign counter_mismatch = mismatch;
endmodule

// *** hw/dms_proc.sv ***
// Processor end: APB orders, duplicate writes, own-store read with mate reread on parity error, time-out
//
// Local design decisions: the APB slave port and the placing of the registers.
module dms_proc #(
    parameter int TIMEOUT = dms_pkg::TIMEOUT_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dms_pkg::APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    dms_bus_if.proc own,
    dms_bus_if.proc mate
);
    import dms_pkg::*;

    localparam int TMO_W = $clog2(TIMEOUT + 1);
    localparam logic [TMO_W-1:0] TMO_LAST = TMO_W'(TIMEOUT - 1);

    typedef enum logic [2:0] {
        PS_IDLE = 3'b001,
        PS_WAIT = 3'b010,
        PS_REREAD = 3'b100
    } dms_proc_state_t;

    dms_proc_state_t state;
    dms_proc_state_t next_state;
    dms_cmd_t cmd;
    logic auto_c;
    logic compl_w;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] wdata;
    logic [WORD_W-1:0] rdata;
    logic go_own;
    logic go_mate;
    logic own_done;
    logic mate_done;
    logic need_mate;
    logic done;
    logic tmo;
    logic wpe;
    logic perr;
    logic used_mate;
    logic [TMO_W-1:0] tmo_cnt;
    logic [31:0] rd_mux;

    // APB decode; writes are refused while an order runs
    wire idle = state == PS_IDLE;
    wire wr_acc = psel && penable && pwrite && idle;
    wire hit_ctrl = paddr == OFS_CTRL;
    wire hit_addr = paddr == OFS_ADDR;
    wire hit_wdata = paddr == OFS_WDATA;
    wire hit_rdata = paddr == OFS_RDATA;
    wire hit_stat = paddr == OFS_STATUS;
    wire hit = hit_ctrl || hit_addr || hit_wdata || hit_rdata || hit_stat;
    wire start = wr_acc && hit_ctrl && pwdata[CTL_START];
    wire dms_cmd_t new_cmd = dms_cmd_t'(pwdata[CTL_CMD +: 2]);

    // Completion tracking across both stores
    wire own_bad = parity_lo_bad(own.rdata) || parity_hi_bad(own.rdata);
    wire mate_bad = parity_lo_bad(mate.rdata) || parity_hi_bad(mate.rdata);
    wire own_fin = own_done || own.complete;
    wire mate_fin = mate_done || mate.complete || !need_mate;
    wire wait_end = (state == PS_WAIT) && own_fin && mate_fin;
    wire reread = wait_end && (cmd == CMD_READ) && own_bad;
    wire rr_end = (state == PS_REREAD) && mate.complete;
    wire tmo_fire = !idle && (tmo_cnt == TMO_LAST) && !wait_end && !rr_end;
    wire fin = (wait_end && !reread) || rr_end || tmo_fire;

    // Order sequence
    always_comb begin
        next_state = state;
        case (state)
            PS_IDLE: begin
                if (start) begin
                    next_state = PS_WAIT;
                end
            end
            PS_WAIT: begin
                if (reread && !tmo_fire) begin
                    next_state = PS_REREAD;
                end else if (fin) begin
                    next_state = PS_IDLE;
                end
            end
            PS_REREAD: begin
                if (fin) begin
                    next_state = PS_IDLE;
                end
            end
            default: begin
                next_state = PS_IDLE;
            end
        endcase
    end

    // State, go pulses and time-out count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PS_IDLE;
            go_own <= 1'b0;
            go_mate <= 1'b0;
            tmo_cnt <= '0;
        end else if (ce) begin
            state <= next_state;
            go_own <= start;
            go_mate <= (start && (new_cmd != CMD_READ)) || reread;
            tmo_cnt <= (start || reread || idle) ? '0 : tmo_cnt + 1'b1;
        end
    end

    // Software order fields
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd <= CMD_READ;
            auto_c <= 1'b0;
            compl_w <= 1'b0;
            addr <= '0;
            wdata <= '0;
        end else if (ce && wr_acc) begin
            if (hit_ctrl) begin
                cmd <= new_cmd;
                auto_c <= pwdata[CTL_AUTO];
                compl_w <= pwdata[CTL_COMPL];
            end
            if (hit_addr) begin
                addr <= pwdata[ADDR_W-1:0];
            end
            if (hit_wdata) begin
                wdata <= add_parity(pwdata[DATA_W-1:0]);
            end
        end
    end

    // Per-store completion latches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_done <= 1'b0;
            mate_done <= 1'b0;
            need_mate <= 1'b0;
        end else if (ce) begin
            own_done <= (state == PS_WAIT) && own_fin && !wait_end;
            mate_done <= (state == PS_WAIT) && (mate_done || mate.complete) && !wait_end;
            if (start) begin
                need_mate <= new_cmd != CMD_READ;
            end
        end
    end

    // Results; status flags cleared by the next start, rdata kept until replaced
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done <= 1'b0;
            tmo <= 1'b0;
            wpe <= 1'b0;
            perr <= 1'b0;
            used_mate <= 1'b0;
            rdata <= '0;
        end else if (ce) begin
            if (start) begin
                done <= 1'b0;
                tmo <= 1'b0;
                wpe <= 1'b0;
                perr <= 1'b0;
                used_mate <= 1'b0;
            end
            if (fin) begin
                done <= 1'b1;
                tmo <= tmo_fire;
            end
            if (wait_end) begin
                wpe <= own.wp_error || (need_mate && mate.wp_error);
                rdata <= own.rdata;
            end
            if (rr_end && !mate_bad) begin
                rdata <= mate.rdata;
                used_mate <= 1'b1;
            end
            perr <= !start && (perr || (rr_end && mate_bad));
        end
    end

    // Register read mux, latched in the setup phase
    always_comb begin
        rd_mux = '0;
        if (hit_ctrl) begin
            rd_mux[CTL_CMD +: 2] = cmd;
            rd_mux[CTL_AUTO] = auto_c;
            rd_mux[CTL_COMPL] = compl_w;
        end
        if (hit_addr) begin
            rd_mux[ADDR_W-1:0] = addr;
        end
        if (hit_wdata) begin
            rd_mux[WORD_W-1:0] = wdata;
        end
        if (hit_rdata) begin
            rd_mux[WORD_W-1:0] = rdata;
        end
        if (hit_stat) begin
            rd_mux[ST_BUSY] = !idle;
            rd_mux[ST_DONE] = done;
            rd_mux[ST_TMO] = tmo;
            rd_mux[ST_WPE] = wpe;
            rd_mux[ST_PERR] = perr;
            rd_mux[ST_MATE] = used_mate;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && psel && !penable) begin
            prdata <= rd_mux;
        end
    end

    // APB handshake and bus drive
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign own.go = go_own;
    assign own.cmd = cmd;
    assign own.addr = addr;
    assign own.wdata = wdata;
    assign own.auto_correct = auto_c;
    assign own.compl_write = compl_w;
    assign mate.go = go_mate;
    assign mate.cmd = cmd;
    assign mate.addr = addr;
    assign mate.wdata = wdata;
    assign mate.auto_correct = auto_c;
    assign mate.compl_write = compl_w;
endmodule

// *** testbench/dms_bus_sva.sv ***
// Assertions on the link between processor end and own store
module dms_bus_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic go,
    input wire dms_pkg::dms_cmd_t cmd,
    input wire logic [dms_pkg::ADDR_W-1:0] addr,
    input wire logic busy,
    input wire logic complete,
    input wire logic [dms_pkg::WORD_W-1:0] rdata,
    input wire logic wp_error,
    input wire logic refresh_active,
    input wire logic rep_go,
    input wire logic [dms_pkg::ADDR_W-1:0] rep_addr,
    input wire logic counter_mismatch
);
    timeunit 1ns;
    timeprecision 1ps;
    import dms_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Order accepted by the store
    wire take = go && !busy && ce;

    a_take_busy: assert property (take |=> busy until complete)
        else $error("busy not held until complete");
    a_answer_idle: assert property (take && !refresh_active |-> ##[2:10] complete)
        else $error("idle order late");
    a_answer_refresh: assert property (take |-> ##[2:18] complete)
        else $error("order beyond two cycles");
    a_not_early: assert property (take |=> !complete [*6])
        else $error("complete too early");
    a_complete_pulse: assert property (complete |=> !complete)
        else $error("complete wider than one cycle");
    a_no_go_busy: assert property (busy |-> !go)
        else $error("go while busy");
    a_rdata_hold: assert property ($changed(rdata) |-> complete)
        else $error("rdata moved without complete");
    a_wp_write: assert property ($rose(wp_error) |-> complete && cmd == CMD_WRITE)
        else $error("protect error outside write");
    a_repeat_bus: assert property ($past(ce) |->
        rep_go == $past(go) && rep_addr == $past(addr))
        else $error("repeater differs");
    a_count_match: assert property (!counter_mismatch)
        else $error("refresh counters disagree");

    c_refresh_take: cover property (take && refresh_active);
    c_wp_refused: cover property (complete && wp_error);
    c_wp_load: cover property (take && cmd == CMD_WP_LOAD);
endmodule

// *** testbench/duplicated_main_store_controller_test.sv ***
// Bench: processor end joined to two stores, driven over APB
module duplicated_main_store_controller_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dms_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic proc_ce = 1'b1;
    logic store_ce = 1'b1;
    logic mate_ce = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, q, st;
    logic pready, pslverr, last_err, rep_go, refresh_active, counter_mismatch;
    logic ref_seen = 1'b0;
    logic [ADDR_W-1:0] rep_addr;
    logic [17:0] ad [4] = '{18'h00000, 18'h12345, 18'h3ffff, 18'h08001};
    logic [23:0] dt [4] = '{24'h000001, 24'hfedcba, 24'h800000, 24'h13579b};
    int n_fail = 0;
    int comparisons = 0;
    int cyc = 0;

    dms_bus_if own_bus();
    dms_bus_if mate_bus();
    dms_proc #(.TIMEOUT(64)) i_dms_proc (.pclk(pclk), .presetn(presetn), .ce(proc_ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .own(own_bus), .mate(mate_bus));
    dms_store i_dms_store (.pclk(pclk), .presetn(presetn), .ce(store_ce), .bus(own_bus),
        .rep_go(rep_go), .rep_cmd(), .rep_addr(rep_addr), .rep_wdata(), .rep_auto_correct(),
        .rep_compl_write(), .refresh_active(refresh_active),
        .counter_mismatch(counter_mismatch));
    dms_store i_dms_store_mate (.pclk(pclk), .presetn(presetn), .ce(mate_ce),
        .bus(mate_bus), .rep_go(), .rep_cmd(), .rep_addr(), .rep_wdata(),
        .rep_auto_correct(), .rep_compl_write(), .refresh_active(), .counter_mismatch());
    dms_bus_sva i_dms_bus_sva (.pclk(pclk), .presetn(presetn), .ce(store_ce),
        .go(own_bus.go), .cmd(own_bus.cmd), .addr(own_bus.addr), .busy(own_bus.busy),
        .complete(own_bus.complete), .rdata(own_bus.rdata), .wp_error(own_bus.wp_error),
        .refresh_active(refresh_active), .rep_go(rep_go), .rep_addr(rep_addr),
        .counter_mismatch(counter_mismatch));

    // Clock and watchdog
    initial forever #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (refresh_active === 1'b1) ref_seen <= 1'b1;
        if (cyc > 30000) begin
            n_fail++;
            conclude();
        end
    end

    // Stored word with odd parity
    function automatic logic [25:0] wd(input logic [23:0] d);
        return {~^d[23:16], ~^d[15:0], d};
    endfunction

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // One store order; leaves status in st, result word in q
    task automatic op(input logic [4:0] c, input logic [17:0] a, input logic [23:0] d);
        st = 32'h0;
        apb(1'b1, OFS_ADDR, {14'h0, a});
        apb(1'b1, OFS_WDATA, {8'h0, d});
        apb(1'b1, OFS_CTRL, {27'h0, c});
        for (int i = 0; i < 300 && st[ST_DONE] !== 1'b1; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            st = q;
        end
        apb(1'b0, OFS_RDATA, 32'h0);
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic conclude();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            op(5'h03, ad[k], dt[k]);
            check(st & 32'h1f, 32'h02);
        end
        for (int k = 0; k < 8; k++) begin
            op(5'h01, ad[k % 4], 24'h0);
            check(q, wd(dt[k % 4]));
        end
        op(5'h05, 18'h0, 24'h01);
        op(5'h03, 18'h0, 24'h5a5a5a);
        check(st & 32'h1f, 32'h0a);
        op(5'h01, 18'h0, 24'h0);
        check(q, wd(dt[0]));
        op(5'h03, 18'h01000, 24'h00f00f);
        check(st & 32'h1f, 32'h02);
        op(5'h05, 18'h0, 24'h00);
        op(5'h03, 18'h0, 24'h5a5a5a);
        op(5'h01, 18'h0, 24'h0);
        check(q, wd(24'h5a5a5a));
        op(5'h13, ad[1], 24'h0c0ffe);
        op(5'h01, ad[1], 24'h0);
        check(st & 32'h1f, 32'h12);
        check(q, {6'h0, ~wd(24'h0c0ffe)});
        op(5'h09, ad[1], 24'h0);
        check(st & 32'h1f, 32'h02);
        check(q, wd(24'h0c0ffe));
        for (int k = 0; k < 200; k++) begin
            op(5'h01, ad[2], 24'h0);
            check(q, wd(dt[2]));
        end
        check({31'h0, ref_seen}, 32'h1);
        // Mate frozen: own copy complemented only, then read falls back to mate
        mate_ce <= 1'b0;
        op(5'h13, ad[3], dt[3]);
        check(st & 32'h1f, 32'h06);
        mate_ce <= 1'b1;
        op(5'h01, ad[3], 24'h0);
        check(st & 32'h3f, 32'h22);
        check(q, wd(dt[3]));
        store_ce <= 1'b0;
        op(5'h01, ad[0], 24'h0);
        check(st & 32'h1f, 32'h06);
        store_ce <= 1'b1;
        apb(1'b0, 12'hffc, 32'h0);
        check({31'h0, last_err}, 32'h1);
        conclude();
    end
endmodule
